// [design/ctfl_flags.sv]
`timescale 1ns/1ns
`include "ctfl_regs.svh"

// Operation
// - Battery recovery sets power-on flag
// - Power-on clears nominal undervoltage, bus and local failure flags
// - Power-on sets wake and wake source
// - Power-on shown in listen-only unless entered from normal, cleared normal
// - Stable wake pin change is local wake
// - Dominant-recessive-dominant within timeout is remote wake
// - Wake sets only in standby, go-sleep, sleep
// - Wake set clears nominal undervoltage and the wake filter timer
// - Wake shown on error and receive outputs in standby, go-sleep, sleep with supply_ok
// - Wake set at power-on, cleared by undervoltage/normal
// - Local wake sets source; polled in normal
// - Source set at power-on, cleared leaving normal
// - Four shorted transmit cycles set bus failure
// - Bus failure cleared power-on, re-entering normal
// - Any local failure in normal or listen-only sets local flag
// - Local flag clears entering normal, or once resolved with txd recessive and rxd low
// - Transmit dominant timeout disables transmitter
// - Receive-transmit short disables transmitter
// - Bus dominant timeout flags without disabling
// - Overtemperature disables transmitter until flag clears
// - Split enabled in normal and listen-only
// - Wake bias follows pin after filter
// - Error output low means flag set
// - Normal: source before fourth edge, then bus failure
module ctfl_flags #(
	parameter int WAKE_CYC = `CTFL_CYC_UP(`CTFL_T_WAKE_NS),
	parameter int WDOM_CYC = `CTFL_CYC_UP(`CTFL_T_WDOM_NS),
	parameter int WREC_CYC = `CTFL_CYC_UP(`CTFL_T_WREC_NS),
	parameter int WTO_CYC = `CTFL_CYC_DN(`CTFL_T_WTO_NS),
	parameter int TXDOM_CYC = `CTFL_CYC_UP(`CTFL_T_TXDOM_NS),
	parameter int BUSDOM_CYC = `CTFL_CYC_UP(`CTFL_T_BUSDOM_NS),
	parameter int CW = 20
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire ctfl_pkg::ctfl_sense_t sense,
	input wire logic txd,
	input wire logic bus_dominant,
	input wire logic wake_pin,
	output logic rxd,
	output logic err_n,
	output logic tx_enable,
	output logic split_enable,
	output logic wake_pullup,
	output logic wake_pulldown
);
	// ======================================================================
	// Bus slave: one wait state so read data comes from a register
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [2:0] mode_r, mode_nxt;
	logic stb_rise;
	logic [31:0] status;

	always_comb begin
		ack_nxt = (avs_read | avs_write) & ~ack_r;
		mode_nxt = mode_r;
		rdata_nxt = rdata_r;
		stb_rise = 1'b0;
		if ((avs_read | avs_write) & ~ack_r) begin
			rdata_nxt = 32'h0000_0000;
			if (avs_write) begin
				if (avs_address == `CTFL_OFF_CTRL)
					mode_nxt = avs_writedata[2:0];
				if (avs_address == `CTFL_OFF_CMD)
					stb_rise = avs_writedata[`CTFL_CMD_STB_RISE];
			end else begin
				case (avs_address)
				`CTFL_OFF_CTRL: rdata_nxt = {29'h0, mode_r};
				`CTFL_OFF_STAT: rdata_nxt = status;
				default: rdata_nxt = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			mode_r <= 3'(`CTFL_CTRL_RST);
		end else begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			mode_r <= mode_nxt;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign avs_readdata = rdata_r;

	// ======================================================================
	// Mode decode; unknown codes behave as standby
	ctfl_pkg::ctfl_mode_t mode;
	logic in_norm, in_lsn, in_low;
	assign mode = ctfl_pkg::ctfl_mode_t'(mode_r);
	assign in_norm = (mode == ctfl_pkg::CTFL_NORMAL);
	assign in_lsn = (mode == ctfl_pkg::CTFL_LISTEN);
	assign in_low = ~in_norm & ~in_lsn;

	function automatic logic [CW-1:0] cnt_inc(input logic [CW-1:0] c,
		input int lim);
		if (int'(c) >= lim)
			cnt_inc = c;
		else
			cnt_inc = c + 1'b1;
	endfunction : cnt_inc

	// ======================================================================
	// Flags, filters and timers
	ctfl_pkg::ctfl_flags_t fl_r, fl_nxt;
	logic prev_norm_r, prev_lsn_r, bat_low_r, came_low_r, came_norm_r;
	logic prev_norm_nxt, prev_lsn_nxt, bat_low_nxt, came_low_nxt;
	logic came_norm_nxt;
	logic wstable_r, wstable_nxt, txd_prev_r, txd_prev_nxt;
	logic [CW-1:0] wcnt_r, wcnt_nxt, txcnt_r, txcnt_nxt;
	logic [CW-1:0] bcnt_r, bcnt_nxt, rwcnt_r, rwcnt_nxt, ph_r, ph_nxt;
	logic [1:0] rw_st_r, rw_st_nxt;
	logic [2:0] bfe_r, bfe_nxt, shc_r, shc_nxt;
	logic txdis_r, txdis_nxt, txto_r, txto_nxt;
	logic pwon_set, local_wake, remote_wake, wake_set, enter_norm;
	logic bus_clamp, loc_ev;

	always_comb begin
		fl_nxt = fl_r;
		prev_norm_nxt = in_norm;
		prev_lsn_nxt = in_lsn;
		bat_low_nxt = sense.bat_low;
		came_low_nxt = came_low_r;
		came_norm_nxt = came_norm_r;
		wstable_nxt = wstable_r;
		wcnt_nxt = '0;
		txd_prev_nxt = txd;
		txcnt_nxt = '0;
		bcnt_nxt = '0;
		rwcnt_nxt = rwcnt_r;
		ph_nxt = ph_r;
		rw_st_nxt = rw_st_r;
		bfe_nxt = bfe_r;
		shc_nxt = shc_r;
		txdis_nxt = txdis_r;
		txto_nxt = txto_r;
		local_wake = 1'b0;
		remote_wake = 1'b0;
		enter_norm = in_norm & ~prev_norm_r;
		pwon_set = bat_low_r & ~sense.bat_low;
		if (in_lsn & ~prev_lsn_r) begin
			came_low_nxt = ~prev_norm_r;
			came_norm_nxt = prev_norm_r;
		end
		// Local wake filter; bias only moves once the level is trusted
		if (wake_pin != wstable_r) begin
			wcnt_nxt = cnt_inc(wcnt_r, WAKE_CYC);
			if (int'(wcnt_r) >= WAKE_CYC - 1) begin
				wstable_nxt = wake_pin;
				local_wake = 1'b1;
			end
		end
		// Remote wake: 0 idle, 1 first dominant, 2 recessive, 3 second
		if (rw_st_r != 2'd0)
			rwcnt_nxt = cnt_inc(rwcnt_r, WTO_CYC);
		ph_nxt = cnt_inc(ph_r, WTO_CYC);
		case (rw_st_r)
		2'd0: if (bus_dominant) begin
			rw_st_nxt = 2'd1;
			ph_nxt = '0;
			rwcnt_nxt = '0;
		end
		2'd1: if (!bus_dominant) begin
			rw_st_nxt = (int'(ph_r) >= WDOM_CYC - 1) ? 2'd2 : 2'd0;
			ph_nxt = '0;
		end
		2'd2: if (bus_dominant) begin
			rw_st_nxt = (int'(ph_r) >= WREC_CYC - 1) ? 2'd3 : 2'd1;
			ph_nxt = '0;
			if (int'(ph_r) < WREC_CYC - 1)
				rwcnt_nxt = '0;
		end
		2'd3: begin
			if (int'(ph_r) >= WDOM_CYC - 1) begin
				remote_wake = 1'b1;
				rw_st_nxt = 2'd0;
			end else if (!bus_dominant)
				rw_st_nxt = 2'd0;
		end
		default: rw_st_nxt = 2'd0;
		endcase
		if (rw_st_r != 2'd0 && int'(rwcnt_r) >= WTO_CYC && !remote_wake)
			rw_st_nxt = 2'd0;
		wake_set = (local_wake | remote_wake) & in_low;
		// Bus failure: count shorted dominant-recessive transmit cycles
		if (in_norm) begin
			if (txd_prev_r == 1'b0 && txd == 1'b1) begin
				if (bfe_r != 3'd7)
					bfe_nxt = bfe_r + 3'd1;
				if (sense.bus_short) begin
					shc_nxt = (shc_r == 3'd7) ? shc_r : shc_r + 3'd1;
					if (shc_r >= 3'(`CTFL_BF_EDGES - 1))
						fl_nxt.busf = 1'b1;
				end else
					shc_nxt = '0;
			end
		end
		// Local failures; dominant clamps use saturating timers
		if (!txd && (in_norm | in_lsn))
			txcnt_nxt = cnt_inc(txcnt_r, TXDOM_CYC);
		if (bus_dominant && (in_norm | in_lsn))
			bcnt_nxt = cnt_inc(bcnt_r, BUSDOM_CYC);
		if (int'(txcnt_r) >= TXDOM_CYC - 1 && !txd)
			txto_nxt = 1'b1;
		if (txd)
			txto_nxt = 1'b0;
		bus_clamp = int'(bcnt_r) >= BUSDOM_CYC && bus_dominant;
		if ((in_norm | in_lsn) & (txto_nxt | sense.txrx_short |
			sense.overtemp)) begin
			txdis_nxt = 1'b1;
		end
		loc_ev = (in_norm | in_lsn) & (txto_nxt | sense.txrx_short |
			sense.overtemp | bus_clamp);
		if (fl_r.locf & ~loc_ev & ~txto_r & ~sense.txrx_short &
			~sense.overtemp & rxd == 1'b0 & txd) begin
			fl_nxt.locf = 1'b0;
		end
		// Clamp indication is not retained
		if (!bus_dominant && !txdis_r && !sense.txrx_short &&
			!sense.overtemp && !txto_r)
			fl_nxt.locf = fl_r.locf & ~bus_clamp & ~(bcnt_r != '0);
		if (loc_ev)
			fl_nxt.locf = 1'b1;
		// Mode-driven clears come before wake and power-on sets so those win; bus and local failure sets come earlier and lose
		if (enter_norm) begin
			fl_nxt.pwon = 1'b0;
			fl_nxt.wake = 1'b0;
			fl_nxt.busf = 1'b0;
			fl_nxt.locf = 1'b0;
			bfe_nxt = '0;
			shc_nxt = '0;
		end
		if (!in_norm && prev_norm_r)
			fl_nxt.wsrc = 1'b0;
		if (!fl_nxt.locf)
			txdis_nxt = 1'b0;
		if (stb_rise)
			fl_nxt.uvnom = 1'b0;
		if (sense.vnom_low & ~fl_r.uvnom) begin
			fl_nxt.uvnom = 1'b1;
			fl_nxt.wake = 1'b0;
		end
		if (wake_set) begin
			fl_nxt.wake = 1'b1;
			fl_nxt.uvnom = 1'b0;
			wcnt_nxt = '0;
			if (local_wake)
				fl_nxt.wsrc = 1'b1;
		end
		if (pwon_set) begin
			fl_nxt.pwon = 1'b1;
			fl_nxt.uvnom = 1'b0;
			fl_nxt.wake = 1'b1;
			fl_nxt.wsrc = 1'b1;
			fl_nxt.busf = 1'b0;
			fl_nxt.locf = 1'b0;
			txdis_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fl_r <= 6'b111000; // power-on: pwon, wake and source set
			prev_norm_r <= 1'b0;
			prev_lsn_r <= 1'b0;
			bat_low_r <= 1'b0;
			came_low_r <= 1'b0;
			came_norm_r <= 1'b0;
			wstable_r <= 1'b0;
			wcnt_r <= '0;
			txd_prev_r <= 1'b1;
			txcnt_r <= '0;
			bcnt_r <= '0;
			rwcnt_r <= '0;
			ph_r <= '0;
			rw_st_r <= 2'd0;
			bfe_r <= 3'd0;
			shc_r <= 3'd0;
			txdis_r <= 1'b0;
			txto_r <= 1'b0;
		end else begin
			fl_r <= fl_nxt;
			prev_norm_r <= prev_norm_nxt;
			prev_lsn_r <= prev_lsn_nxt;
			bat_low_r <= bat_low_nxt;
			came_low_r <= came_low_nxt;
			came_norm_r <= came_norm_nxt;
			wstable_r <= wstable_nxt;
			wcnt_r <= wcnt_nxt;
			txd_prev_r <= txd_prev_nxt;
			txcnt_r <= txcnt_nxt;
			bcnt_r <= bcnt_nxt;
			rwcnt_r <= rwcnt_nxt;
			ph_r <= ph_nxt;
			rw_st_r <= rw_st_nxt;
			bfe_r <= bfe_nxt;
			shc_r <= shc_nxt;
			txdis_r <= txdis_nxt;
			txto_r <= txto_nxt;
		end
	end

	// ======================================================================
	// Pin outputs
	logic err_flag;
	always_comb begin
		err_flag = 1'b0;
		if (in_norm)
			err_flag = (bfe_r < 3'(`CTFL_BF_EDGES)) ? fl_r.wsrc
				: fl_r.busf;
		else if (in_lsn)
			err_flag = came_norm_r ? fl_r.locf
				: fl_r.pwon;
		else
			err_flag = fl_r.wake & sense.supply_ok;
	end

	assign err_n = ~err_flag;
	// Receive path mirrors the bus in active modes, the wake flag otherwise
	assign rxd = in_low ? ~(fl_r.wake & sense.supply_ok)
		: ~bus_dominant;
	assign tx_enable = in_norm & ~txdis_r;
	assign split_enable = in_norm | in_lsn;
	assign wake_pullup = wstable_r;
	assign wake_pulldown = ~wstable_r;

	assign status = {22'h0, wstable_r, split_enable, err_n, txdis_r,
		fl_r.uvnom, fl_r.locf, fl_r.busf, fl_r.wsrc, fl_r.wake, fl_r.pwon};
endmodule : ctfl_flags

// [inc/ctfl_regs.svh]
`ifndef CTFL_REGS_SVH
`define CTFL_REGS_SVH
// ==========================================================================
// Register map (Avalon-MM, byte addresses, one word each)
`define CTFL_ADDR_W 4
`define CTFL_OFF_CTRL 4'h0
`define CTFL_OFF_STAT 4'h4
`define CTFL_OFF_CMD 4'h8
// Control register fields
`define CTFL_CTRL_MODE_LSB 0
`define CTFL_CTRL_MODE_W 3
`define CTFL_CTRL_RST 32'h0000_0001
// Command register bits (write one to pulse)
`define CTFL_CMD_STB_RISE 0
// Status register bit positions
`define CTFL_ST_PWON 0
`define CTFL_ST_WAKE 1
`define CTFL_ST_WSRC 2
`define CTFL_ST_BUSF 3
`define CTFL_ST_LOCF 4
`define CTFL_ST_UVNOM 5
`define CTFL_ST_TXDIS 6
`define CTFL_ST_ERRN 7
`define CTFL_ST_SPLIT 8
`define CTFL_ST_WBIAS 9
// ==========================================================================
// Times in ns and derived cycle counts at 100 MHz
`define CTFL_CLK_NS 10
`define CTFL_T_WAKE_NS 50000
`define CTFL_T_WDOM_NS 5000
`define CTFL_T_WREC_NS 5000
`define CTFL_T_WTO_NS 1000000
`define CTFL_T_TXDOM_NS 2700000
`define CTFL_T_BUSDOM_NS 2700000
`define CTFL_T_MODE_NS 8000
`define CTFL_CYC_UP(t) (((t) + `CTFL_CLK_NS - 1) / `CTFL_CLK_NS)
`define CTFL_CYC_DN(t) ((t) / `CTFL_CLK_NS)
`define CTFL_BF_EDGES 4
`endif

// [inc/ctfl_pkg.sv]
package ctfl_pkg;
	typedef enum logic [2:0] {
		CTFL_NORMAL = 3'b000,
		CTFL_LISTEN = 3'b001,
		CTFL_STANDBY = 3'b010,
		CTFL_GOSLEEP = 3'b011,
		CTFL_SLEEP = 3'b100
	} ctfl_mode_t;
	typedef struct packed {
		logic pwon;
		logic wake;
		logic wsrc;
		logic busf;
		logic locf;
		logic uvnom;
	} ctfl_flags_t;
	typedef struct packed {
		logic supply_ok;
		logic bat_low;
		logic vnom_low;
		logic overtemp;
		logic txrx_short;
		logic bus_short;
	} ctfl_sense_t;
endpackage : ctfl_pkg

// [dv/ctfl_ctrl_model.sv]
`timescale 1ns/1ns
// ==========================================================================
// Controller model: drives transmit data, four dominant-recessive cycles
module ctfl_ctrl_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic hold_low,
	output logic txd,
	output logic busy
);
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	assign busy = (cnt_r != 5'h0);
	// Three high then three low per cycle; idles recessive
	assign txd = !(hold_low || (busy && ((cnt_r - 5'h1) % 5'h6) < 5'h3));
	always_comb begin
		cnt_nxt = busy ? cnt_r - 5'h1 : (go ? 5'h18 : 5'h0);
	end
	always_ff @(posedge sys_clk) begin
		cnt_r <= rst_n ? cnt_nxt : 5'h0;
	end
endmodule : ctfl_ctrl_model

// [dv/ctfl_flags_checker.sv]
`timescale 1ns/1ns
module ctfl_flags_checker #(
	parameter int TXDOM_CYC = 20
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire ctfl_pkg::ctfl_sense_t sense,
	input wire logic txd,
	input wire logic wake_pin,
	input wire logic tx_enable,
	input wire logic split_enable,
	input wire logic wake_pullup,
	input wire logic wake_pulldown
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ======================================================================
	// Low-time counter on transmit data, saturates to avoid wrap
	logic [7:0] lo_r;
	logic [7:0] lo_nxt;
	always_comb begin
		lo_nxt = txd ? 8'h0 : ((lo_r == 8'hff) ? lo_r : lo_r + 8'h1);
	end
	always_ff @(posedge sys_clk) begin
		lo_r <= rst_n ? lo_nxt : 8'h0;
	end
	// ======================================================================
	// Properties
	property p_ack;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("no answer in one cycle");
	property p_unmapped;
		avs_read && !avs_waitrequest && avs_address == 4'hc |->
			avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
	property p_txdom;
		lo_r > TXDOM_CYC + 1 |-> !tx_enable;
	endproperty
	a_txdom: assert property (p_txdom) else $error("tx on after timeout");
	property p_short;
		sense.txrx_short |-> ##[0:2] !tx_enable;
	endproperty
	a_short: assert property (p_short) else $error("tx on with short");
	property p_hot;
		sense.overtemp |-> ##[0:2] !tx_enable;
	endproperty
	a_hot: assert property (p_hot) else $error("tx on when hot");
	property p_split;
		tx_enable |-> split_enable;
	endproperty
	a_split: assert property (p_split) else $error("split off in normal");
	property p_bias_hold;
		$changed(wake_pin) |=> $stable(wake_pullup)[*3];
	endproperty
	a_bias_hold: assert property (p_bias_hold) else $error("bias unfiltered");
	property p_bias_excl;
		wake_pullup |-> !wake_pulldown;
	endproperty
	a_bias_excl: assert property (p_bias_excl) else $error("bias both ways");
endmodule : ctfl_flags_checker

bind ctfl_flags ctfl_flags_checker #(.TXDOM_CYC(TXDOM_CYC)) i_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .sense(sense), .txd(txd),
	.wake_pin(wake_pin), .tx_enable(tx_enable), .split_enable(split_enable),
	.wake_pullup(wake_pullup), .wake_pulldown(wake_pulldown));

// [dv/ctfl_flags_tb.sv]
`timescale 1ns/1ns
`include "ctfl_regs.svh"
module ctfl_flags_tb;
	logic sys_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic avs_waitrequest, txd, bus_dominant = 1'b0, wake_pin = 1'b0;
	logic rxd, err_n, tx_enable, split_enable, wake_pullup, busy;
	logic wake_pulldown;
	logic go = 1'b0, hold_low = 1'b0;
	ctfl_pkg::ctfl_sense_t sense = 6'h20;
	int fails = 0, checked = 0;
	always #5 sys_clk = ~sys_clk;
	ctfl_flags #(.WAKE_CYC(4), .WDOM_CYC(3), .WREC_CYC(3),
		.TXDOM_CYC(20), .BUSDOM_CYC(20)) i_dut (.sys_clk(sys_clk),
		.rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.sense(sense), .txd(txd), .bus_dominant(bus_dominant),
		.wake_pin(wake_pin), .rxd(rxd), .err_n(err_n), .tx_enable(tx_enable),
		.split_enable(split_enable), .wake_pullup(wake_pullup),
		.wake_pulldown(wake_pulldown));
	ctfl_ctrl_model i_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .go(go),
		.hold_low(hold_low), .txd(txd), .busy(busy));
	// ======================================================================
	// Tasks
	task results;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge sys_clk iff avs_waitrequest === 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask : acc
	// Mode change, then let the error output settle before polling
	task md(input ctfl_pkg::ctfl_mode_t m);
		acc(1'b1, `CTFL_OFF_CTRL, {29'h0, m});
		repeat (800) @(posedge sys_clk);
	endtask : md
	task fl(input string n, input logic [5:0] e);
		acc(1'b0, `CTFL_OFF_STAT, 32'h0);
		chk(n, {26'h0, e}, {26'h0, q[5:0]});
	endtask : fl
	task wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wt
	task edges;
		go <= 1'b1;
		wt(1);
		go <= 1'b0;
		wt(1);
		while (busy) @(posedge sys_clk);
		wt(3);
	endtask : edges
	// ======================================================================
	// Watchdog
	initial begin
		wt(60000);
		fails++;
		$display("watchdog expired");
		results();
	end
	// ======================================================================
	// Tests
	initial begin
		wt(10);
		rst_n <= 1'b1;
		wt(1);
		acc(1'b0, `CTFL_OFF_CTRL, 32'h0);
		chk("ctrl", `CTFL_CTRL_RST, q);
		acc(1'b0, 4'hc, 32'h0);
		chk("unmapped", 32'h0, q);
		fl("reset", 6'h07);
		chk("err_n pwon", 32'h0, {31'h0, err_n});
		chk("split", 32'h1, {31'h0, split_enable});
		$display("test reset done");
		md(ctfl_pkg::CTFL_NORMAL);
		fl("normal", 6'h04);
		chk("err_n src", 32'h0, {31'h0, err_n});
		wake_pin <= 1'b1;
		wt(10);
		fl("no wake normal", 6'h04);
		chk("pullup", 32'h1, {31'h0, wake_pullup});
		chk("pulldown", 32'h0, {31'h0, wake_pulldown});
		edges();
		chk("err_n busf", 32'h1, {31'h0, err_n});
		$display("test normal done");
		md(ctfl_pkg::CTFL_STANDBY);
		fl("standby", 6'h00);
		chk("split off", 32'h0, {31'h0, split_enable});
		wake_pin <= 1'b0;
		wt(2);
		wake_pin <= 1'b1;
		wt(10);
		fl("glitch", 6'h00);
		wake_pin <= 1'b0;
		wt(10);
		fl("local", 6'h06);
		chk("err_n wake", 32'h0, {31'h0, err_n});
		chk("rxd wake", 32'h0, {31'h0, rxd});
		sense.vnom_low <= 1'b1;
		wt(1);
		sense.vnom_low <= 1'b0;
		wt(2);
		fl("uvnom", 6'h24);
		wake_pin <= 1'b1;
		wt(10);
		fl("uv clear", 6'h06);
		$display("test local wake done");
		md(ctfl_pkg::CTFL_NORMAL);
		md(ctfl_pkg::CTFL_STANDBY);
		bus_dominant <= 1'b1;
		wt(5);
		bus_dominant <= 1'b0;
		wt(5);
		bus_dominant <= 1'b1;
		wt(5);
		bus_dominant <= 1'b0;
		wt(3);
		fl("remote", 6'h02);
		chk("rxd remote", 32'h0, {31'h0, rxd});
		$display("test remote wake done");
		md(ctfl_pkg::CTFL_NORMAL);
		sense.bus_short <= 1'b1;
		edges();
		sense.bus_short <= 1'b0;
		fl("busf", 6'h08);
		chk("err_n busf", 32'h0, {31'h0, err_n});
		md(ctfl_pkg::CTFL_LISTEN);
		md(ctfl_pkg::CTFL_NORMAL);
		fl("busf clear", 6'h00);
		$display("test bus failure done");
		for (int i = 0; i < 3; i++) begin
			hold_low <= (i == 0);
			sense.txrx_short <= (i == 1);
			sense.overtemp <= (i == 2);
			wt(25);
			hold_low <= 1'b0;
			sense.txrx_short <= 1'b0;
			sense.overtemp <= 1'b0;
			wt(3);
			chk("tx off", 32'h0, {31'h0, tx_enable});
			fl("locf", 6'h10);
			md(ctfl_pkg::CTFL_LISTEN);
			chk("err_n locf", 32'h0, {31'h0, err_n});
			bus_dominant <= 1'b1;
			wt(3);
			bus_dominant <= 1'b0;
			wt(2);
			fl("locf clear", 6'h00);
			md(ctfl_pkg::CTFL_NORMAL);
			chk("tx on", 32'h1, {31'h0, tx_enable});
		end
		bus_dominant <= 1'b1;
		wt(25);
		fl("clamp", 6'h10);
		chk("tx kept", 32'h1, {31'h0, tx_enable});
		bus_dominant <= 1'b0;
		wt(3);
		fl("clamp gone", 6'h00);
		$display("test local failure done");
		sense.vnom_low <= 1'b1;
		wt(1);
		sense.vnom_low <= 1'b0;
		sense.bat_low <= 1'b1;
		wt(3);
		sense.bat_low <= 1'b0;
		wt(3);
		fl("power on", 6'h07);
		$display("test power on done");
		results();
	end
endmodule : ctfl_flags_tb
